// ==== common/brap_pkg.sv ====
// Shared constants for the backed RAM access port and its host controller
package brap_pkg;

   // Link byte width and RAM geometry
   localparam int BRAP_DATA_W = 8;
   localparam int BRAP_PTR_W = 9;
   localparam int BRAP_RAM_DEPTH = 512;

   // Device register addresses on the link
   localparam logic [7:0] BRAP_REG_FIRST = 8'h00;
   localparam logic [7:0] BRAP_REG_PTR_HIGH = 8'h1a;
   localparam logic [7:0] BRAP_REG_PTR_LOW = 8'h1b;
   localparam logic [7:0] BRAP_REG_WRITE_PORT = 8'h1c;
   localparam logic [7:0] BRAP_REG_READ_PORT = 8'h1d;

   // Last address reached by auto advance before wrapping
   localparam logic [7:0] BRAP_REG_WRAP = BRAP_REG_PTR_LOW;

   // Position of the pointer top bit in the high pointer register
   localparam int BRAP_TOP_BIT_POS = 0;

   // Constant steps and fills
   localparam logic [7:0] BRAP_ADDR_STEP = 8'h01;
   localparam logic [8:0] BRAP_PTR_STEP = 9'h001;
   localparam logic [8:0] BRAP_PTR_RESET = 9'h000;
   localparam logic [7:0] BRAP_BYTE_ZERO = 8'h00;
   localparam logic [6:0] BRAP_UNUSED_HIGH = 7'h00;

   // Host controller software register map
   localparam int BRAP_SW_ADDR_W = 3;
   localparam int BRAP_SW_DATA_W = 16;
   localparam logic [2:0] BRAP_SW_PTR = 3'h0;
   localparam logic [2:0] BRAP_SW_WDATA = 3'h1;
   localparam logic [2:0] BRAP_SW_RDCMD = 3'h2;
   localparam logic [2:0] BRAP_SW_STATUS = 3'h3;
   localparam logic [2:0] BRAP_SW_RDATA = 3'h4;
   localparam logic [15:0] BRAP_SW_ZERO = 16'h0000;

   // Host controller sequencer states
   typedef enum logic [2:0] {
      BRAP_IDLE,
      BRAP_PHIGH,
      BRAP_PLOW,
      BRAP_WRITE,
      BRAP_READ,
      BRAP_RWAIT
   } brap_host_st_t;

endpackage : brap_pkg

// ==== common/brap_link_if.sv ====
`timescale 1ns/100ps
// Register link between host controller and RAM access port
interface brap_link_if;
   logic selStb;        // Host: byte on linkData is a register address
   logic linkWr;        // Host: byte on linkData is written to register
   logic linkRd;        // Host: read one byte from current register
   logic [7:0] linkData; // Host: address or write byte
   logic [7:0] rdData;  // Device: read byte, one cycle after linkRd
   logic rdOe;          // Device: high while device drives rdData
   logic [7:0] rdWire;  // Resolved read line level

   // Released line reads as all ones, as if pulled up
   assign rdWire = rdOe ? rdData : 8'hff;

   modport dev (
      input selStb,
      input linkWr,
      input linkRd,
      input linkData,
      output rdData,
      output rdOe
   );

   modport host (
      output selStb,
      output linkWr,
      output linkRd,
      output linkData,
      input rdData,
      input rdOe
   );
endinterface : brap_link_if

// ==== hw/brap_device.sv ====
`timescale 1ns/100ps
// How it works
// - 512 battery-backed RAM bytes survive battery mode
// - Nine-bit pointer: top bit 1Ah, low 1Bh
// - Register address advances, wraps after 1Bh to 00h; 1Ch and above hold
// - Bytes written at 1Ch go to RAM
// - Bytes read at 1Dh come from RAM
// - Host addresses port registers explicitly
// - Host loads pointer via 1Ah then 1Bh
// - Host selects 1Ch then streams writes
// - Host selects 1Dh then streams reads
// - On battery, every link input is ignored
// - On battery, every link output released
module brap_device
   import brap_pkg::*;
#(
   parameter int RAM_DEPTH = BRAP_RAM_DEPTH
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic onBattery,
   brap_link_if.dev link,
   output logic [8:0] ramPointer,
   output logic batteryMode
);

   ////////////////////////////////////////////////////////////////////////
   // State

   // All control state of the port in one record
   typedef struct packed {
      logic batMeta;         // First stage of battery level synchroniser
      logic onBat;           // Synchronised battery level
      logic [7:0] regAddr;   // Register address pointer
      logic [8:0] ptr;       // RAM pointer
      logic [7:0] rdData;    // Read byte held for the link
      logic rdOe;            // Read byte valid this cycle
   } brap_dev_state_t;

   brap_dev_state_t state_reg; // Registered state
   brap_dev_state_t state_next; // Next state
   logic ramWe;                // RAM write strobe this cycle
   logic [7:0] ramQ;           // RAM byte at current pointer

   // Storage array; never reset so contents outlive main power
   logic [7:0] ram [RAM_DEPTH];

   ////////////////////////////////////////////////////////////////////////
   // Helpers

   // Advance register address; port registers hold so bytes can stream
   function automatic logic [7:0] brap_advance(input logic [7:0] a);
      logic [7:0] r;
      r = a;
      if (a < BRAP_REG_WRAP) begin
         r = a + BRAP_ADDR_STEP;
      end else if (a == BRAP_REG_WRAP) begin
         r = BRAP_REG_FIRST;
      end
      return r;
   endfunction : brap_advance

   ////////////////////////////////////////////////////////////////////////
   // RAM

   // Asynchronous read of the byte under the pointer
   assign ramQ = ram[state_reg.ptr];

   // Synchronous write at the pointer, no reset on purpose
   always_ff @(posedge clk) begin
      if (ramWe) begin
         ram[state_reg.ptr] <= link.linkData;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Next state

   // Decode link strobes against the current register address
   always_comb begin
      state_next = state_reg;
      ramWe = 1'b0;
      // Two-stage synchroniser for the battery level pin
      state_next.batMeta = onBattery;
      state_next.onBat = state_reg.batMeta;
      // Read strobe to the link lasts a single cycle
      state_next.rdOe = 1'b0;
      if (state_reg.onBat) begin
         // Backup supply: link inputs have no effect
         state_next.rdOe = 1'b0;
      end else if (link.selStb) begin
         // Address phase loads the register address pointer
         state_next.regAddr = link.linkData;
      end else if (link.linkWr) begin
         // Data write to the selected register
         unique case (state_reg.regAddr)
            BRAP_REG_PTR_HIGH: begin
               // Only the top pointer bit is kept
               state_next.ptr[BRAP_PTR_W-1] =
                  link.linkData[BRAP_TOP_BIT_POS];
            end
            BRAP_REG_PTR_LOW: begin
               // Low eight pointer bits
               state_next.ptr[7:0] = link.linkData;
            end
            BRAP_REG_WRITE_PORT: begin
               // Store byte then step pointer
               ramWe = 1'b1;
               state_next.ptr = state_reg.ptr + BRAP_PTR_STEP;
            end
            default: begin
               // Other registers belong to other blocks
            end
         endcase
         state_next.regAddr = brap_advance(state_reg.regAddr);
      end else if (link.linkRd) begin
         // Data read from the selected register
         state_next.rdOe = 1'b1;
         unique case (state_reg.regAddr)
            BRAP_REG_PTR_HIGH: begin
               // Unused bits answer zero
               state_next.rdData =
                  {BRAP_UNUSED_HIGH, state_reg.ptr[BRAP_PTR_W-1]};
            end
            BRAP_REG_PTR_LOW: begin
               // Low pointer bits
               state_next.rdData = state_reg.ptr[7:0];
            end
            BRAP_REG_READ_PORT: begin
               // Fetch byte then step pointer
               state_next.rdData = ramQ;
               state_next.ptr = state_reg.ptr + BRAP_PTR_STEP;
            end
            default: begin
               // Write port and foreign registers read zero
               state_next.rdData = BRAP_BYTE_ZERO;
            end
         endcase
         state_next.regAddr = brap_advance(state_reg.regAddr);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Registers

   // Single state register, constants only under reset
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg.batMeta <= 1'b0;
         state_reg.onBat <= 1'b0;
         state_reg.regAddr <= BRAP_REG_FIRST;
         state_reg.ptr <= BRAP_PTR_RESET;
         state_reg.rdData <= BRAP_BYTE_ZERO;
         state_reg.rdOe <= 1'b0;
      end else begin
         state_reg <= state_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Outputs

   // Read byte comes straight from its flip-flops
   assign link.rdData = state_reg.rdData;

   // Line released at once when battery mode starts
   assign link.rdOe = state_reg.rdOe & ~state_reg.onBat;

   // Observation of pointer and supply state
   assign ramPointer = state_reg.ptr;
   assign batteryMode = state_reg.onBat;

endmodule : brap_device

// ==== hw/brap_host.sv ====
// The plain strobed port was decided locally.
`timescale 1ns/100ps
// Host controller: turns software commands into link sequences
module brap_host
   import brap_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   brap_link_if.host link,
   input wire logic [2:0] swAddr,
   input wire logic [15:0] swWdata,
   input wire logic swWr,
   input wire logic swRd,
   output logic [15:0] swRdata
);

   ////////////////////////////////////////////////////////////////////////
   // State

   // All host state in one record
   typedef struct packed {
      brap_host_st_t st;     // Sequencer state
      logic [8:0] ptr;       // Last pointer requested
      logic [7:0] wbyte;     // Byte to write
      logic [7:0] rbyte;     // Last byte read
      logic [7:0] sel;       // Register known selected in device
      logic selKnown;        // sel is trustworthy
      logic noAns;           // Last read got no answer
      logic selStb;          // Link address strobe
      logic linkWr;          // Link write strobe
      logic linkRd;          // Link read strobe
      logic [7:0] linkData;  // Link byte
      logic [15:0] swRdata;  // Software read data
   } brap_host_state_t;

   brap_host_state_t state_reg; // Registered state
   brap_host_state_t state_next; // Next state

   ////////////////////////////////////////////////////////////////////////
   // Next state

   // Software decode and link sequencing
   always_comb begin
      state_next = state_reg;
      state_next.selStb = 1'b0;
      state_next.linkWr = 1'b0;
      state_next.linkRd = 1'b0;
      state_next.swRdata = BRAP_SW_ZERO;
      // Software reads answer the next cycle
      if (swRd) begin
         unique case (swAddr)
            BRAP_SW_PTR: state_next.swRdata = {7'h00, state_reg.ptr};
            BRAP_SW_STATUS: state_next.swRdata =
               {14'h0000, state_reg.noAns, state_reg.st != BRAP_IDLE};
            BRAP_SW_RDATA: state_next.swRdata = {8'h00, state_reg.rbyte};
            default: state_next.swRdata = BRAP_SW_ZERO;
         endcase
      end
      unique case (state_reg.st)
         BRAP_IDLE: begin
            // Commands accepted only while idle
            if (swWr && swAddr == BRAP_SW_PTR) begin
               // Select high pointer register first
               state_next.ptr = swWdata[8:0];
               state_next.selStb = 1'b1;
               state_next.linkData = BRAP_REG_PTR_HIGH;
               state_next.selKnown = 1'b0;
               state_next.st = BRAP_PHIGH;
            end else if (swWr && swAddr == BRAP_SW_WDATA) begin
               state_next.wbyte = swWdata[7:0];
               if (state_reg.selKnown &&
                   state_reg.sel == BRAP_REG_WRITE_PORT) begin
                  // Port still selected: stream the byte
                  state_next.linkWr = 1'b1;
                  state_next.linkData = swWdata[7:0];
               end else begin
                  // Select write port explicitly
                  state_next.selStb = 1'b1;
                  state_next.linkData = BRAP_REG_WRITE_PORT;
                  state_next.sel = BRAP_REG_WRITE_PORT;
                  state_next.selKnown = 1'b1;
                  state_next.st = BRAP_WRITE;
               end
            end else if (swWr && swAddr == BRAP_SW_RDCMD) begin
               if (state_reg.selKnown &&
                   state_reg.sel == BRAP_REG_READ_PORT) begin
                  // Port still selected: stream the read
                  state_next.linkRd = 1'b1;
                  state_next.st = BRAP_RWAIT;
               end else begin
                  // Select read port explicitly
                  state_next.selStb = 1'b1;
                  state_next.linkData = BRAP_REG_READ_PORT;
                  state_next.sel = BRAP_REG_READ_PORT;
                  state_next.selKnown = 1'b1;
                  state_next.st = BRAP_READ;
               end
            end
         end
         BRAP_PHIGH: begin
            // Top bit; device address then moves to low register
            state_next.linkWr = 1'b1;
            state_next.linkData = {7'h00, state_reg.ptr[8]};
            state_next.st = BRAP_PLOW;
         end
         BRAP_PLOW: begin
            // Low bits written without a new address phase
            state_next.linkWr = 1'b1;
            state_next.linkData = state_reg.ptr[7:0];
            state_next.st = BRAP_IDLE;
         end
         BRAP_WRITE: begin
            // Data byte after write port selection
            state_next.linkWr = 1'b1;
            state_next.linkData = state_reg.wbyte;
            state_next.st = BRAP_IDLE;
         end
         BRAP_READ: begin
            // Read strobe after read port selection
            state_next.linkRd = 1'b1;
            state_next.st = BRAP_RWAIT;
         end
         BRAP_RWAIT: begin
            if (state_reg.linkRd) begin
               // Strobe still on the link: device answers next cycle
               state_next.st = BRAP_RWAIT;
            end else begin
               // Answer is due in exactly this cycle
               if (link.rdOe) begin
                  state_next.rbyte = link.rdData;
                  state_next.noAns = 1'b0;
               end else begin
                  state_next.noAns = 1'b1;
               end
               state_next.st = BRAP_IDLE;
            end
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // Registers

   // Single state register
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg <= '0;
         state_reg.st <= BRAP_IDLE;
      end else begin
         state_reg <= state_next;
      end
   end

   // Outputs straight from flip-flops
   assign link.selStb = state_reg.selStb;
   assign link.linkWr = state_reg.linkWr;
   assign link.linkRd = state_reg.linkRd;
   assign link.linkData = state_reg.linkData;
   assign swRdata = state_reg.swRdata;

endmodule : brap_host

// ==== test/brap_link_sva.sv ====
`timescale 1ns/100ps
// Link checker: watches both ends of the register link
module brap_link_sva
   import brap_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic selStb,
   input wire logic linkWr,
   input wire logic linkRd,
   input wire logic [7:0] linkData,
   input wire logic [7:0] rdData,
   input wire logic rdOe,
   input wire logic [7:0] rdWire,
   input wire logic [8:0] ramPointer,
   input wire logic batteryMode
);
   // One clock domain, one reset
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   ////////////////////////////////////////////////////////////////////////
   // Device side
   AST_RD_ANSWER: assert property (linkRd && !batteryMode |=> rdOe)
      else $error("read strobe got no answer next cycle");
   AST_RD_CAUSE: assert property (
      rdOe |-> $past(linkRd) && !$past(batteryMode))
      else $error("read answer without a taken read strobe");
   AST_BAT_QUIET: assert property (
      batteryMode && $past(batteryMode) |-> !rdOe)
      else $error("read line driven in battery mode");
   AST_WIRE_FREE: assert property (!rdOe |-> rdWire == 8'hff)
      else $error("released read line not at idle level");
   AST_WIRE_LEVEL: assert property (rdOe |-> rdWire == rdData)
      else $error("driven read line differs from read byte");
   AST_PTR_STEP: assert property (
      rdOe |-> ramPointer == $past(ramPointer) + 9'h001)
      else $error("ram pointer did not step after port read");

   ////////////////////////////////////////////////////////////////////////
   // Host side
   AST_ONE_STROBE: assert property ($onehot0({selStb, linkWr, linkRd}))
      else $error("more than one link strobe at once");
   AST_PTR_SEQ: assert property (
      selStb && linkData == BRAP_REG_PTR_HIGH
      |=> linkWr && linkData[7:1] == 7'h00 ##1 linkWr)
      else $error("pointer load not followed by two writes");
   AST_WR_SEL: assert property (
      selStb && linkData == BRAP_REG_WRITE_PORT |=> linkWr && !linkRd)
      else $error("write port select not followed by a write");
   AST_RD_SEL: assert property (
      selStb && linkData == BRAP_REG_READ_PORT |=> linkRd)
      else $error("read port select not followed by a read");

   // Main scenarios reached
   CV_READ: cover property (rdOe);
   CV_PTR: cover property (selStb && linkData == BRAP_REG_PTR_HIGH);
   CV_BAT: cover property (batteryMode ##1 linkWr);
endmodule : brap_link_sva

// ==== test/tb_backed_ram_access_port.sv ====
`timescale 1ns/100ps
// Bench: host and device joined by the link, driven from software port
module tb_backed_ram_access_port
   import brap_pkg::*;
;
   logic clk;                // 20 MHz clock
   logic rst_n;              // Active low reset
   logic onBattery;          // Backup supply level
   logic [2:0] swAddr;       // Software address
   logic [15:0] swWdata;     // Software write data
   logic swWr;               // Software write strobe
   logic swRd;               // Software read strobe
   logic [15:0] swRdata;     // Software read data
   logic [8:0] ramPointer;   // Device RAM pointer
   logic batteryMode;        // Device battery state
   logic [15:0] val;         // Last value read
   logic [8:0] ptrHold;      // Pointer before battery mode
   int badCount;             // Mismatches
   int totalChecks;          // Comparisons made
   logic [7:0] dat [5] = '{8'ha5, 8'h3c, 8'h0f, 8'hd2, 8'h61}; // Bytes

   brap_link_if link();

   brap_device #(.RAM_DEPTH(512)) i_brap_device (.clk(clk), .rst_n(rst_n),
      .onBattery(onBattery), .link(link), .ramPointer(ramPointer),
      .batteryMode(batteryMode));
   brap_host i_brap_host (.clk(clk), .rst_n(rst_n), .link(link),
      .swAddr(swAddr), .swWdata(swWdata), .swWr(swWr), .swRd(swRd),
      .swRdata(swRdata));
   brap_link_sva i_brap_link_sva (.clk(clk), .rst_n(rst_n),
      .selStb(link.selStb), .linkWr(link.linkWr), .linkRd(link.linkRd),
      .linkData(link.linkData), .rdData(link.rdData), .rdOe(link.rdOe),
      .rdWire(link.rdWire), .ramPointer(ramPointer),
      .batteryMode(batteryMode));

   ////////////////////////////////////////////////////////////////////////
   // Clock
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   // Verdict and end of run
   task automatic endSim;
      if (badCount == 0 && totalChecks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : endSim

   // Compare and report
   task automatic check(input string nm, input logic [15:0] exp,
                        input logic [15:0] got);
      totalChecks++;
      if (got !== exp) begin
         badCount++;
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
   endtask : check

   // Software write, one strobe cycle then a gap
   task automatic swWrite(input logic [2:0] a, input logic [15:0] d);
      swAddr <= a;
      swWdata <= d;
      swWr <= 1'b1;
      @(posedge clk);
      swWr <= 1'b0;
      @(posedge clk);
   endtask : swWrite

   // Software read, data sampled in the cycle after the strobe
   task automatic getReg(input logic [2:0] a, output logic [15:0] v);
      swAddr <= a;
      swRd <= 1'b1;
      @(posedge clk);
      swRd <= 1'b0;
      @(negedge clk);
      v = swRdata;
      @(posedge clk);
   endtask : getReg

   // Poll status until the sequencer is free
   task automatic waitIdle;
      int n;
      n = 0;
      val = 16'h0001;
      while (val[0] !== 1'b0 && n < 20) begin
         getReg(BRAP_SW_STATUS, val);
         n++;
      end
      check("busy", 16'h0000, {15'h0000, val[0]});
   endtask : waitIdle

   // Load pointer, store a byte, start a port read
   task automatic setPtr(input logic [8:0] p);
      swWrite(BRAP_SW_PTR, {7'h00, p});
      waitIdle();
   endtask : setPtr
   task automatic putByte(input logic [7:0] b);
      swWrite(BRAP_SW_WDATA, {8'h00, b});
      waitIdle();
   endtask : putByte
   task automatic rdCmd;
      swWrite(BRAP_SW_RDCMD, BRAP_SW_ZERO);
      repeat (4) @(posedge clk);
      waitIdle();
   endtask : rdCmd

   // Port read and compare of the returned byte
   task automatic getByte(input logic [7:0] exp);
      rdCmd();
      getReg(BRAP_SW_RDATA, val);
      check("rdata", {8'h00, exp}, val);
   endtask : getByte

   ////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      rst_n = 1'b0;
      onBattery = 1'b0;
      swAddr = 3'h0;
      swWdata = 16'h0000;
      swWr = 1'b0;
      swRd = 1'b0;
      badCount = 0;
      totalChecks = 0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      // Streamed writes across the top of the RAM and the top bit
      setPtr(9'h1fe);
      getReg(BRAP_SW_PTR, val);
      check("swPtr", 16'h01fe, val);
      for (int i = 0; i < 3; i++) putByte(dat[i]);
      setPtr(9'h0ff);
      for (int i = 3; i < 5; i++) putByte(dat[i]);
      // Streamed reads with pointer wrap from last byte to zero
      setPtr(9'h1fe);
      for (int i = 0; i < 3; i++) getByte(dat[i]);
      check("wrapPtr", 16'h0001, {7'h00, ramPointer});
      setPtr(9'h0ff);
      for (int i = 3; i < 5; i++) getByte(dat[i]);
      ptrHold = ramPointer;
      // Battery mode: link inputs ignored, read line released
      onBattery <= 1'b1;
      repeat (4) @(posedge clk);
      check("batMode", 16'h0001, {15'h0000, batteryMode});
      setPtr(9'h0ff);
      putByte(8'h99);
      check("batPtr", {7'h00, ptrHold}, {7'h00, ramPointer});
      rdCmd();
      getReg(BRAP_SW_STATUS, val);
      check("noAnswer", 16'h0002, {14'h0000, val[1], 1'b0});
      onBattery <= 1'b0;
      repeat (4) @(posedge clk);
      check("mainMode", 16'h0000, {15'h0000, batteryMode});
      // Contents kept through battery mode
      setPtr(9'h0ff);
      getByte(dat[3]);
      getByte(dat[4]);
      // Unmapped software address reads zero
      getReg(3'h7, val);
      check("unmapped", 16'h0000, val);
      endSim();
   end

   // Watchdog against a hang
   initial begin
      repeat (6000) @(posedge clk);
      badCount++;
      endSim();
   end
endmodule : tb_backed_ram_access_port
